// >>> sep_eeprom_port.sv
// serial eeprom command port: link shifter, status, protection, write cycle
//
// Overview of operation
// RL1: output bit changes after each falling edge
// RL2: input bits captured on rising clock edge
// RL3: deselect tri-states output, standby unless writing
// RL4: nothing accepted before first select falling edge
// RL5: write-protect low refuses all nonvolatile writes
// RL6: protect falling during select aborts write
// RL7: pause input freezes sequence while clock low
// RL8: commands shift into an eight-bit opcode register
// RL9: all bytes move most significant bit first
// RL10: first bit on first rising edge; clock static
// RL11: both idle-low and idle-high clock modes work
// RL12: no write completes without enable latch set
// RL13: enable opcode sets latch, disable clears it
// RL14: latch cleared at reset and write completion
// RL15: status readable any time, even while writing
// RL16: status holds protect, latch and busy bits
// RL17: busy flag set while writing, others read one
// RL18: protect bits only written by status write
// RL19: protected quarters readable but never written
// RL20: read opcode plus address streams array data
// RL21: write opcode plus address stores page data
// RL22: read address increments and wraps to zero
// RL23: enable opcode counts only if deselected after
// RL24: write starts only on byte boundary; page wraps
// RL25: unknown opcodes ignored, output stays tri-stated
`default_nettype none
module sep_eeprom_port
  import sep_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES_P = sep_pkg::WRITE_CYCLES
) (
  input  wire logic ref_clk_in,
  input  wire logic rst_b_in,
  input  wire logic spi_clk_in,
  input  wire logic cs_b_in,
  input  wire logic si_in,
  input  wire logic hold_b_in,
  input  wire logic wp_b_in,
  output logic      so_out,
  output logic      so_oe_b_out,
  output logic      standby_out
);
  import sep_pkg::*;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // protected-quarter decode from the two protect bits
  function automatic logic prot_hit(input logic [7:0] a, input logic [1:0] bp);
    logic hit;
    hit = 1'b0;
    unique case (bp)
      2'h0: hit = 1'b0;
      2'h1: hit = (a[7:6] == 2'h3);
      2'h2: hit = a[7];
      2'h3: hit = 1'b1;
    endcase
    return hit;
  endfunction : prot_hit

  function automatic logic op_known(input logic [7:0] op);
    return (op == ENABLE_WRITE_OPCODE) || (op == DISABLE_WRITE_OPCODE) ||
           (op == READ_STATUS_OPCODE)  || (op == WRITE_STATUS_OPCODE)  ||
           (op == READ_ARRAY_OPCODE)   || (op == WRITE_ARRAY_OPCODE);
  endfunction : op_known

  // ------------------------------------------------------------
  // shared state
  // ------------------------------------------------------------
  logic [7:0]  mem_r [256];
  logic        wel_r;
  logic [1:0]  bp_r;
  logic        wr_busy;
  logic        wr_done;
  sep_frame_t  frm_r;
  sep_frame_t  frm_nxt;
  logic        fresh_r;
  logic [7:0]  sh_r;
  logic [7:0]  ptr_r;
  logic [7:0]  ptr_nxt;
  logic        mute_r;
  logic        mute_nxt;
  logic [7:0]  st_lat_r;
  logic [7:0]  st_lat_nxt;
  logic        busy_l;
  logic        so_r;
  logic        so_oe_b_r;

  // ------------------------------------------------------------
  // link side: shift in on rising edge
  // ------------------------------------------------------------
  // pause is set up by the master while the link clock is low, so it is
  // stable at every link edge and is read directly on this clock; edges
  // while deselected are ignored so the frame summary stays put for the core
  wire        run_l     = hold_b_in && !cs_b_in;                // [RL7]
  wire [2:0]  bit_cur   = fresh_r ? 3'h0 : frm_r.nbits;         // [RL10]
  wire [1:0]  byte_cur  = fresh_r ? 2'h0 : frm_r.nbytes;
  wire [7:0]  shift_nxt = {(fresh_r ? 7'h00 : sh_r[6:0]), si_in}; // [RL9]
  wire        byte_done = (bit_cur == 3'h7);
  wire [7:0]  op_cur    = fresh_r ? 8'h00 : frm_r.op;
  wire        op_bad    = !op_known(shift_nxt) ||
                          (busy_l && shift_nxt != READ_STATUS_OPCODE);
  wire [7:0]  status_w  = busy_l ? STATUS_BUSY_VALUE :
                          {4'h0, bp_r, wel_r, 1'b0};            // [RL16] [RL17]

  // busy level carried over to the link clock
  sep_sync2 #(.W(1)) u_busy_sync (
    .clk_in (spi_clk_in),
    .d_in   (wr_busy),
    .q_out  (busy_l)
  );

  // next frame summary; first edge of a frame restarts the counters
  always_comb begin
    frm_nxt    = frm_r;
    ptr_nxt    = ptr_r;
    mute_nxt   = fresh_r ? 1'b0 : mute_r;
    st_lat_nxt = st_lat_r;
    if (fresh_r) begin
      frm_nxt.tog    = ~frm_r.tog;
      frm_nxt.mask   = 4'h0;
      frm_nxt.nbytes = 2'h0;
      frm_nxt.op     = 8'h00;
    end
    frm_nxt.nbits = bit_cur + 3'h1;                             // [RL8]
    if (byte_done) begin
      if (byte_cur != BYTES_SATURATED) begin
        frm_nxt.nbytes = byte_cur + 2'h1;
      end
      if (byte_cur == 2'h0) begin
        frm_nxt.op = shift_nxt;                                 // [RL8]
        mute_nxt   = op_bad;                                    // [RL25]
        st_lat_nxt = status_w;                                  // [RL15]
      end else if (byte_cur == 2'h1) begin
        frm_nxt.addr = shift_nxt;
        ptr_nxt      = shift_nxt;                               // [RL20] [RL21]
      end else begin
        ptr_nxt = ptr_r + 8'h01;                                // [RL22]
        if (op_cur == WRITE_ARRAY_OPCODE) begin
          frm_nxt.page[ptr_r[1:0]] = shift_nxt;                 // [RL24]
          frm_nxt.mask[ptr_r[1:0]] = 1'b1;
        end
      end
    end
  end

  // frame start flag, preset whenever the device is deselected
  always_ff @(posedge spi_clk_in or posedge cs_b_in) begin
    if (cs_b_in) begin
      fresh_r <= 1'b1;
    end else if (run_l) begin
      fresh_r <= 1'b0;
    end
  end

  // rising edge capture; frozen while paused or deselected. the core reset
  // also clears it, so the frame toggle starts equal to the core's copy
  always_ff @(posedge spi_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sh_r     <= 8'h00;
      frm_r    <= '0;
      ptr_r    <= 8'h00;
      mute_r   <= 1'b0;
      st_lat_r <= 8'h00;
    end else if (run_l) begin                                   // [RL2] [RL7]
      sh_r     <= shift_nxt;
      frm_r    <= frm_nxt;
      ptr_r    <= ptr_nxt;
      mute_r   <= mute_nxt;
      st_lat_r <= st_lat_nxt;
    end
  end

  // ------------------------------------------------------------
  // link side: shift out on falling edge
  // ------------------------------------------------------------
  // array words are read without a handshake: the array only changes at
  // commit, while deselected, and array reads are refused while busy
  wire        rd_stat = (op_cur == READ_STATUS_OPCODE) && (byte_cur != 2'h0);
  wire        rd_arr  = (op_cur == READ_ARRAY_OPCODE) && byte_cur[1];
  wire [7:0]  tx_byte = rd_stat ? st_lat_r : mem_r[ptr_r];
  wire        drive_l = !fresh_r && !mute_r && run_l && (rd_stat || rd_arr);

  always_ff @(negedge spi_clk_in or posedge cs_b_in) begin
    if (cs_b_in) begin
      so_oe_b_r <= 1'b1;                                        // [RL3]
      so_r      <= 1'b0;
    end else begin
      so_oe_b_r <= !drive_l;                                    // [RL11] [RL25]
      so_r      <= tx_byte[~bit_cur];                           // [RL1] [RL9]
    end
  end

  // ------------------------------------------------------------
  // core side: synchronised pins and frame toggle
  // ------------------------------------------------------------
  logic       cs_hi_s;
  logic       wp_hi_s;
  logic       tog_s;
  logic       seen_tog_r;
  logic       armed_r;
  logic       wp_drop_r;
  logic       standby_r;

  sep_sync2 #(.W(3)) u_core_sync (
    .clk_in (ref_clk_in),
    .d_in   ({cs_b_in, wp_b_in, frm_r.tog}),
    .q_out  ({cs_hi_s, wp_hi_s, tog_s})
  );

  // frame fields are stable here: link edges are ignored while deselected.
  // frame_end marks the first core cycle that sees a finished frame; a frame
  // that ends while a write cycle runs is dropped, as the contract refuses it
  wire frame_end = cs_hi_s && (tog_s != seen_tog_r);
  wire commit    = frame_end && armed_r && !wr_busy;
  wire one_byte  = (frm_r.nbytes == 2'h1) && (frm_r.nbits == 3'h0);
  wire two_byte  = (frm_r.nbytes == 2'h2) && (frm_r.nbits == 3'h0);
  wire page_done = (frm_r.nbytes == BYTES_SATURATED) && (frm_r.nbits == 3'h0);
  wire wr_allow  = wel_r && wp_hi_s && !wp_drop_r;              // [RL5] [RL6] [RL12]
  wire do_enable_write_opcode   = commit && one_byte && (frm_r.op == ENABLE_WRITE_OPCODE);  // [RL23]
  wire do_disable_write_opcode   = commit && one_byte && (frm_r.op == DISABLE_WRITE_OPCODE);
  wire do_write_status_opcode   = commit && two_byte && wr_allow &&
                   (frm_r.op == WRITE_STATUS_OPCODE);
  wire do_write  = commit && page_done && wr_allow &&
                   (frm_r.op == WRITE_ARRAY_OPCODE);            // [RL24]
  wire wr_start  = do_write_status_opcode || do_write;

  // ------------------------------------------------------------
  // core side: power-up arming and write-protect watch
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      armed_r    <= 1'b0;
      wp_drop_r  <= 1'b0;
      seen_tog_r <= 1'b0;
      standby_r  <= 1'b0;
    end else begin
      armed_r    <= armed_r || !cs_hi_s;                        // [RL4]
      wp_drop_r  <= cs_hi_s ? (wp_drop_r && !frame_end) : (wp_drop_r || !wp_hi_s);  // [RL6]
      seen_tog_r <= cs_hi_s ? tog_s : seen_tog_r;
      standby_r  <= cs_hi_s && !wr_busy;                        // [RL3]
    end
  end

  // ------------------------------------------------------------
  // core side: latch, protect bits and array
  // ------------------------------------------------------------
  // a new enable in the same cycle as a finishing write wins over the automatic clear
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      wel_r <= WEL_RESET;                                       // [RL14]
      bp_r  <= BLOCK_PROTECT_RESET;
    end else begin
      if (wr_done || do_disable_write_opcode) begin
        wel_r <= 1'b0;                                          // [RL13] [RL14]
      end
      if (do_enable_write_opcode) begin
        wel_r <= 1'b1;                                          // [RL13]
      end
      if (do_write_status_opcode) begin
        bp_r <= frm_r.addr[BLOCK_PROTECT_HIGH_POS:BLOCK_PROTECT_LOW_POS];  // [RL18]
      end
    end
  end

  // page bytes land at commit; protected quarters are skipped
  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < PAGE_BYTES; i++) begin
      if (do_write && frm_r.mask[i] &&
          !prot_hit({frm_r.addr[7:2], 2'(i)}, bp_r)) begin      // [RL19]
        mem_r[{frm_r.addr[7:2], 2'(i)}] <= frm_r.page[i];
      end
    end
  end

  // the timer alone decides how long busy stands
  sep_write_timer #(.CYCLES(WRITE_CYCLES_P)) u_timer (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .start_in   (wr_start),
    .busy_out   (wr_busy),                                      // [RL17]
    .done_out   (wr_done)
  );

  assign so_out      = so_r;
  assign so_oe_b_out = so_oe_b_r;
  assign standby_out = standby_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_wel_needed: assert property (wr_start |-> wel_r) // [RL12]
    else $error("write cycle started without enable latch");
  a_wel_cleared: assert property (wr_done && !do_enable_write_opcode |=> !wel_r) // [RL14]
    else $error("enable latch not cleared after write cycle");
  a_enable_write_opcode_sets: assert property (do_enable_write_opcode |=> wel_r ##1 wel_r) // [RL13]
    else $error("enable opcode did not set latch");
  a_wp_blocks: assert property (wr_start |-> wp_hi_s && !wp_drop_r) // [RL5]
    else $error("write started with protect low");
  a_first_select: assert property (!armed_r |-> !wel_r && !wr_busy) // [RL4]
    else $error("activity before first select");
  a_bp_written: assert property (do_write_status_opcode |=> bp_r == $past(frm_r.addr[3:2])) // [RL18]
    else $error("protect bits not taken from status write");
  a_busy_holds: assert property (wr_start |=> wr_busy [*8]) // [RL17]
    else $error("busy flag dropped early");
  a_deselect_z: assert property ($rose(cs_hi_s) |-> so_oe_b_out) // [RL3]
    else $error("output driven while deselected");
  a_standby_busy: assert property (wr_busy |=> !standby_out) // [RL3]
    else $error("standby shown during write cycle");
  a_busy_ends: assert property (wr_done |-> !wr_busy) // [RL17]
    else $error("busy flag still set at write end");
  a_disable_write_opcode_clears: assert property (do_disable_write_opcode |=> !wel_r) // [RL13]
    else $error("disable opcode did not clear latch");
  a_commit_once: assert property (commit |=> !commit) // [RL23]
    else $error("one frame committed twice");

  // link domain checks
  a_bad_op_mute: assert property (@(posedge spi_clk_in) disable iff (cs_b_in)
      run_l && byte_done && byte_cur == 2'h0 && !op_known(shift_nxt)
      |=> mute_r) // [RL25]
    else $error("unknown opcode not muted");
  a_status_busy: assert property (@(posedge spi_clk_in) disable iff (cs_b_in)
      run_l && byte_done && byte_cur == 2'h0 && busy_l |=> st_lat_r == 8'hff) // [RL17]
    else $error("status not all ones while busy");
  a_mute_quiet: assert property (@(posedge spi_clk_in) disable iff (cs_b_in)
      mute_r |-> so_oe_b_out) // [RL25]
    else $error("muted frame drove the output");

  // covers for the main scenarios
  c_enable_write_opcode: cover property (do_enable_write_opcode);
  c_page_write: cover property (do_write);
  c_status_poll: cover property (wr_busy && $rose(cs_hi_s));
  c_pause_held: cover property (@(posedge spi_clk_in) !cs_b_in && !hold_b_in);
  c_protect_skip: cover property (do_write && bp_r != 2'h0);
endmodule : sep_eeprom_port
`default_nettype wire

// >>> sep_pkg.sv
// constants, opcodes and frame carrier for the serial eeprom port
`default_nettype none
package sep_pkg;
  // ------------------------------------------------------------
  // instruction opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] ENABLE_WRITE_OPCODE  = 8'h06;
  localparam logic [7:0] DISABLE_WRITE_OPCODE = 8'h04;
  localparam logic [7:0] READ_STATUS_OPCODE   = 8'h05;
  localparam logic [7:0] WRITE_STATUS_OPCODE  = 8'h01;
  localparam logic [7:0] READ_ARRAY_OPCODE    = 8'h03;
  localparam logic [7:0] WRITE_ARRAY_OPCODE   = 8'h02;

  // ------------------------------------------------------------
  // status byte layout and values
  // ------------------------------------------------------------
  localparam int unsigned WRITE_IN_PROGRESS_POS  = 0;
  localparam int unsigned WRITE_ENABLE_LATCH_POS = 1;
  localparam int unsigned BLOCK_PROTECT_LOW_POS  = 2;
  localparam int unsigned BLOCK_PROTECT_HIGH_POS = 3;
  localparam logic [7:0]  STATUS_BUSY_VALUE      = 8'hff;
  localparam logic [1:0]  BLOCK_PROTECT_RESET    = 2'h0;
  localparam logic        WEL_RESET              = 1'b0;

  // ------------------------------------------------------------
  // frame counting and write cycle timing
  // ------------------------------------------------------------
  localparam int unsigned PAGE_BYTES       = 4;
  localparam logic [1:0]  BYTES_SATURATED  = 2'h3;
  localparam int unsigned WRITE_TIME_MS    = 5;
  localparam int unsigned REF_CLK_HZ       = 20_000_000;
  localparam int unsigned WRITE_CYCLES     = WRITE_TIME_MS * (REF_CLK_HZ / 1000);

  // frame summary built on the link clock, read by the core after deselect
  typedef struct packed {
    logic                 tog;
    logic [7:0]           op;
    logic [1:0]           nbytes;
    logic [2:0]           nbits;
    logic [7:0]           addr;
    logic [3:0]           mask;
    logic [3:0][7:0]      page;
  } sep_frame_t;
endpackage : sep_pkg
`default_nettype wire

// >>> sep_sync2.sv
// two flip-flop level synchroniser, vector wide
`default_nettype none
module sep_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // ------------------------------------------------------------
  // first stage feeds only the second stage
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    meta_r <= d_in;
    q_r    <= meta_r;
  end

  assign q_out = q_r;
endmodule : sep_sync2
`default_nettype wire

// >>> sep_write_timer.sv
// self-timed nonvolatile write cycle counter
`default_nettype none
module sep_write_timer #(
  parameter int unsigned CYCLES = 100000
) (
  input  wire logic ref_clk_in,
  input  wire logic rst_b_in,
  input  wire logic start_in,
  output logic      busy_out,
  output logic      done_out
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] ONE  = CW'(1);
  logic [CW-1:0] cnt_r;
  logic          done_r;

  // ------------------------------------------------------------
  // count down; done pulses once the count has run out
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= (cnt_r == ONE);
      if (start_in && cnt_r == '0) begin
        cnt_r <= LOAD;
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - ONE;
      end
    end
  end

  assign busy_out = (cnt_r != '0);
  assign done_out = done_r;
endmodule : sep_write_timer
`default_nettype wire

// >>> sep_spi_master_model.sv
// link master model that drives the serial eeprom port
`default_nettype none
module sep_spi_master_model (
  output logic      spi_clk_out,
  output logic      cs_b_out,
  output logic      si_out,
  output logic      hold_b_out,
  input  wire logic so_in,
  input  wire logic so_oe_b_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic cpol;
  // idle: deselected, clock still, pause released
  initial begin
    cpol        = 1'b0;
    spi_clk_out = 1'b0;
    si_out      = 1'b1;
    hold_b_out  = 1'b1;
    #1;
    cs_b_out    = 1'b1;  // late rise gives the port a clean preset edge
  end
  // select with the clock parked at its idle level for the mode
  task automatic sel(input logic m3);
    cpol = m3;
    spi_clk_out <= m3;
    #20;
    cs_b_out <= 1'b0;  // falling select opens every frame
    #20;
  endtask : sel
  // n bits msb first; so is taken just before each rising edge
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      spi_clk_out <= 1'b0;
      si_out      <= tx[i];  // set up while clock low
      #7.5;
      rx[i] = so_oe_b_in ? 1'bz : so_in;
      spi_clk_out <= 1'b1;
      #7.5;
    end
  endtask : xfer
  // pause: hold goes low and high only with the clock low
  task automatic pause(input int n);
    spi_clk_out <= 1'b0;
    #7.5;
    hold_b_out <= 1'b0;
    #5;
    repeat (n) begin
      si_out      <= ~si_out;
      spi_clk_out <= 1'b1;
      #7.5;
      spi_clk_out <= 1'b0;
      #7.5;
    end
    hold_b_out <= 1'b1;
    #5;
  endtask : pause
  // deselect at whatever bit the frame reached, then give the core time to see it
  task automatic desel();
    spi_clk_out <= cpol;
    #10;
    cs_b_out <= 1'b1;
    si_out   <= ~si_out;  // released line must not look stable
    #400;
    repeat (2) begin
      spi_clk_out <= ~cpol;
      #7.5;
      spi_clk_out <= cpol;
      #7.5;
    end
  endtask : desel
endmodule : sep_spi_master_model
`default_nettype wire

// >>> tb_spi_serial_eeprom_port.sv
// self-checking bench for the serial eeprom command port
`default_nettype none
module tb_spi_serial_eeprom_port import sep_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic       ref_clk = 1'b0;
  logic       rst_b   = 1'b0;
  logic       wp_b    = 1'b1;
  logic       spi_clk, cs_b, si, hold_b, so, so_oe_b, standby;
  logic [7:0] rx;
  logic [7:0] rxq [$];
  int         n_fail = 0;
  int         samples_checked = 0;
  // short write cycle keeps the run brief
  sep_eeprom_port #(.WRITE_CYCLES_P(20)) uut (.ref_clk_in(ref_clk), .rst_b_in(rst_b),
    .spi_clk_in(spi_clk), .cs_b_in(cs_b), .si_in(si), .hold_b_in(hold_b), .wp_b_in(wp_b),
    .so_out(so), .so_oe_b_out(so_oe_b), .standby_out(standby));
  sep_spi_master_model master (.spi_clk_out(spi_clk), .cs_b_out(cs_b), .si_out(si),
    .hold_b_out(hold_b), .so_in(so), .so_oe_b_in(so_oe_b));
  always #25 ref_clk = ~ref_clk;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  // one selected frame of whole bytes plus an optional ragged tail
  task automatic frame(input logic [7:0] q[$], input int tail = 0, input logic m3 = 1'b0);
    rxq.delete();
    master.sel(m3);
    foreach (q[i]) begin
      master.xfer(q[i], 8, rx);
      rxq.push_back(rx);
    end
    if (tail > 0) master.xfer(8'h00, tail, rx);
    master.desel();
  endtask : frame
  // bounded wait for the write cycle to end
  task automatic wait_idle();
    int k;
    k = 0;
    while (standby !== 1'b1 && k < 400) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 400) begin
      chk("standby_wait", 8'h01, {7'h0, standby});
      results();
    end
  endtask : wait_idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    frame('{ENABLE_WRITE_OPCODE});
    frame('{WRITE_ARRAY_OPCODE, a, d});
    wait_idle();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    frame('{READ_ARRAY_OPCODE, a, 8'h00});
    chk("array_byte", exp, rx);
  endtask : rd
  task automatic read_status_opcode(input logic [7:0] exp);
    frame('{READ_STATUS_OPCODE, 8'h00});
    chk("status", exp, rx);
  endtask : read_status_opcode
  task automatic t_idle();
    chk("so_oe_b_idle", 8'h01, {7'h0, so_oe_b});
    chk("standby_idle", 8'h01, {7'h0, standby});
    read_status_opcode(8'h00);
    $display("done idle");
  endtask : t_idle
  task automatic t_latch();
    frame('{ENABLE_WRITE_OPCODE});
    read_status_opcode(8'h02);
    frame('{DISABLE_WRITE_OPCODE});
    read_status_opcode(8'h00);
    frame('{ENABLE_WRITE_OPCODE}, 3);
    read_status_opcode(8'h00);
    frame('{ENABLE_WRITE_OPCODE}, 0, 1'b1);
    frame('{READ_STATUS_OPCODE, 8'h00}, 0, 1'b1);
    chk("status_mode3", 8'h02, rx);
    frame('{DISABLE_WRITE_OPCODE});
    $display("done latch");
  endtask : t_latch
  task automatic t_write();
    frame('{ENABLE_WRITE_OPCODE});
    frame('{WRITE_ARRAY_OPCODE, 8'h12, 8'ha5});
    chk("standby_busy", 8'h00, {7'h0, standby});
    read_status_opcode(STATUS_BUSY_VALUE);
    wait_idle();
    read_status_opcode(8'h00);
    rd(8'h12, 8'ha5);
    $display("done write");
  endtask : t_write
  task automatic t_page();
    frame('{ENABLE_WRITE_OPCODE});
    frame('{WRITE_ARRAY_OPCODE, 8'h22, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55});
    wait_idle();
    frame('{READ_ARRAY_OPCODE, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00});
    chk("page_0", 8'h33, rxq[2]);
    chk("page_1", 8'h44, rxq[3]);
    chk("page_2", 8'h55, rxq[4]);
    chk("page_3", 8'h22, rxq[5]);
    wr(8'hff, 8'h77);
    wr(8'h00, 8'h88);
    frame('{READ_ARRAY_OPCODE, 8'hff, 8'h00, 8'h00});
    chk("wrap_ff", 8'h77, rxq[2]);
    chk("wrap_00", 8'h88, rxq[3]);
    $display("done page");
  endtask : t_page
  task automatic t_refuse();
    frame('{WRITE_ARRAY_OPCODE, 8'h22, 8'h01});
    chk("standby_nolatch", 8'h01, {7'h0, standby});
    frame('{ENABLE_WRITE_OPCODE});
    frame('{WRITE_ARRAY_OPCODE, 8'h22, 8'h02}, 3);
    read_status_opcode(8'h02);
    @(posedge ref_clk) wp_b <= 1'b0;
    frame('{WRITE_ARRAY_OPCODE, 8'h22, 8'h03});
    @(posedge ref_clk) wp_b <= 1'b1;
    master.sel(1'b0);
    master.xfer(WRITE_ARRAY_OPCODE, 8, rx);
    master.xfer(8'h22, 8, rx);
    @(posedge ref_clk) wp_b <= 1'b0;
    master.xfer(8'h04, 8, rx);
    master.desel();
    @(posedge ref_clk) wp_b <= 1'b1;
    wait_idle();
    rd(8'h22, 8'h55);
    frame('{8'hff, 8'h00});
    chk("unknown_op_so", 8'hzz, rx);
    frame('{DISABLE_WRITE_OPCODE});
    $display("done refuse");
  endtask : t_refuse
  task automatic t_hold();
    master.sel(1'b0);
    master.xfer(READ_STATUS_OPCODE, 4, rx);
    master.pause(3);
    master.xfer(8'h50, 4, rx);
    master.xfer(8'h00, 8, rx);
    master.desel();
    chk("status_paused", 8'h00, rx);
    $display("done hold");
  endtask : t_hold
  task automatic t_protect();
    logic [7:0] pa [3] = '{8'hc0, 8'h80, 8'h00};
    logic [7:0] pv [3] = '{8'h10, 8'h21, 8'h30};
    for (int k = 0; k < 3; k++) wr(pa[k], pv[k]);
    for (int k = 1; k < 4; k++) begin
      frame('{ENABLE_WRITE_OPCODE});
      frame('{WRITE_STATUS_OPCODE, 8'(k << 2)});
      wait_idle();
      read_status_opcode(8'(k << 2));
      wr(pa[k-1], 8'hee);
      rd(pa[k-1], pv[k-1]);
    end
    frame('{ENABLE_WRITE_OPCODE});
    frame('{WRITE_STATUS_OPCODE, 8'h00});
    wait_idle();
    wr(8'h80, 8'h5c);
    rd(8'h80, 8'h5c);
    $display("done protect");
  endtask : t_protect
  // reset, then the scenarios in order
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_idle();
    t_latch();
    t_write();
    t_page();
    t_refuse();
    t_hold();
    t_protect();
    results();
  end
endmodule : tb_spi_serial_eeprom_port
`default_nettype wire
